// ==== verilog/fetch_pipeline_memory_map.v ====
`timescale 1ns/1ps
`include "fetch_defs.vh"

// Summary of operation
// [RQ1] Clock divided by four into phases.
// [RQ2] Each cycle runs phase one to four.
// [RQ3] Next fetch overlaps current execute.
// [RQ4] Program counter changes flush fetched word.
// [RQ5] Program counter increments in phase one.
// [RQ6] Fetched word latched at phase one.
// [RQ7] Operand read phase two, written phase four.
// [RQ8] Thirteen-bit counter, fourteen-bit program words.
// [RQ9] Addresses above implemented top wrap around.
// [RQ10] Reset starts at zero, interrupts at four.
// [RQ11] Four banks, low 32 hold special registers.
// [RQ12] General RAM placed per bank map.
// [RQ13] Top sixteen bytes shared by all banks.
// [RQ14] Two status bits select the bank.
// [RQ15] File of 256 or 224 bytes.
// [RQ16] Direct address is bank bits plus field.
// [RQ17] Core registers mirrored in all banks.
module fetch_pipeline_memory_map #(
    parameter        PROG_AW = 11,  // Implemented program address bits.
    parameter        LARGE   = 0    // One selects the 256-byte file.
) (
    input  wire        REF_CLK,
    input  wire        RESET,
    output reg  [12:0] PROG_ADDR,
    input  wire [13:0] PROG_DATA,
    output reg  [3:0]  PHASE,
    output reg  [13:0] INSTR_WORD,
    output reg         INSTR_VALID,
    output reg  [7:0]  OPERAND,
    output reg  [7:0]  STATUS_OUT,
    input  wire        EXEC_WR,
    input  wire [7:0]  EXEC_WDATA,
    input  wire        EXEC_FLAGS_WR,
    input  wire [2:0]  EXEC_FLAGS,
    input  wire        EXEC_PC_LOAD,
    input  wire [12:0] EXEC_PC_TARGET,
    input  wire        INT_REQ,
    output reg         INT_TAKEN,
    output reg  [12:0] RETURN_ADDR,
    output reg  [8:0]  SFR_ADDR,
    output reg         SFR_RD,
    input  wire [7:0]  SFR_RDATA,
    output reg         SFR_WR,
    output reg  [7:0]  SFR_WDATA
);

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam [12:0] PROG_MASK = (13'h0001 << PROG_AW) - 13'h0001;
    localparam        FILE_DEPTH = LARGE ? 256 : 224;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    wire [3:0]  phase;             // One-hot phase from the divider.
    reg  [12:0] pc_r;              // Program counter.
    reg  [13:0] fetch_word_r;      // Word fetched during this cycle.
    reg         flush_r;           // Fetched word must be discarded.
    reg  [8:0]  daddr_r;           // Data address of the executing word.
    reg         ext_sfr_r;         // Operand lives outside this block.
    reg         wr_pend_r;         // Destination write captured at phase three.
    reg  [7:0]  wdata_r;           // Captured destination data.
    reg         flags_pend_r;      // Flag update captured at phase three.
    reg  [2:0]  flags_r;           // Captured flag values.
    reg         jump_pend_r;       // Program counter load captured.
    reg  [12:0] target_r;          // Captured jump target.
    reg  [7:0]  status_r;          // Core status flags.
    reg  [7:0]  pointer_r;         // Indirect pointer.
    reg  [7:0]  upper_latch_r;     // Upper program counter latch.
    reg  [7:0]  int_ctl_r;         // Interrupt control.
    reg  [7:0]  file_mem [0:FILE_DEPTH-1]; // General purpose and common RAM.

    // Combinational decode of the operand location.
    reg  [8:0]  daddr_nxt;
    reg  [8:0]  slot;              // Bit 8 marks a hit, bits 7:0 the slot.
    reg  [7:0]  read_nxt;

    // ----------------------------------------------------------------
    // Phase generation
    // ----------------------------------------------------------------
    phase_divider phase_divider_inst (
        .clk     (REF_CLK),
        .rst     (RESET),
        .phase_r (phase)
    );

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    // Maps a 9-bit data address to a file slot. Regions that hold no
    // RAM return a miss, which reads as zero and ignores writes.
    function [8:0] map_slot;
        input [8:0] a;
        reg   [7:0] off;
        begin
            off      = {1'b0, a[6:0]} - {1'b0, `SFR_TOP};
            map_slot = 9'h000;
            if (a[6:0] >= `COMMON_BASE) begin
                // The top sixteen bytes of every bank share one block.
                map_slot = {1'b1, `SLOT_COMMON + {4'h0, a[3:0]}}; // [RQ13]
            end else if (a[6:0] >= `SFR_TOP) begin
                case (a[8:7]) // [RQ12]
                    2'b00: begin
                        map_slot = {1'b1, `SLOT_BANK0 + off};
                    end
                    2'b01: begin
                        map_slot = {1'b1, `SLOT_BANK1 + off};
                    end
                    2'b10: begin
                        // The smaller file stops below offset 50h of bank 2.
                        if ((LARGE != 0) || (a[6:0] < `BANK2_SMALL_TOP)) begin
                            map_slot = {1'b1, `SLOT_BANK2 + off}; // [RQ15]
                        end
                    end
                    default: begin
                        map_slot = 9'h000;
                    end
                endcase
            end
        end
    endfunction

    // Address of the word entering execution, formed from the fetched
    // word, since it is latched on this same phase-one edge.
    always @* begin
        if (fetch_word_r[6:0] == `OFS_INDIRECT_DATA) begin
            // Indirect access: pointer plus its bank bit.
            daddr_nxt = {status_r[`ST_INDIRECT_BANK], pointer_r}; // [RQ15]
        end else begin
            // Direct access: bank bits above the seven-bit field.
            daddr_nxt = {status_r[`ST_BANK_HIGH], status_r[`ST_BANK_LOW],
                         fetch_word_r[6:0]}; // [RQ14] [RQ16]
        end
    end

    // Operand read mux. Core registers answer in every bank because
    // only the low seven bits are compared.
    always @* begin
        slot     = map_slot(daddr_r);
        read_nxt = 8'h00;
        if (daddr_r[6:0] < `SFR_TOP) begin
            case (daddr_r[6:0]) // [RQ11] [RQ17]
                `OFS_PC_LOW:         read_nxt = pc_r[7:0];
                `OFS_STATUS:         read_nxt = status_r;
                `OFS_INDIRECT_PTR:   read_nxt = pointer_r;
                `OFS_PC_UPPER_LATCH: read_nxt = upper_latch_r;
                `OFS_INT_CONTROL:    read_nxt = int_ctl_r;
                `OFS_INDIRECT_DATA:  read_nxt = 8'h00;
                default:             read_nxt = SFR_RDATA;
            endcase
        end else if (slot[8]) begin
            read_nxt = file_mem[slot[7:0]];
        end
    end

    // ----------------------------------------------------------------
    // Fetch and pipeline control
    // ----------------------------------------------------------------
    // Phase one: the counter steps and the previous fetch enters the
    // holding register. Phase four: the new word is captured and any
    // counter change takes effect, which throws that word away.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            pc_r         <= `RESET_VECTOR; // [RQ10]
            PROG_ADDR    <= `RESET_VECTOR;
            fetch_word_r <= 14'h0000;
            flush_r      <= 1'b1;
            INSTR_WORD   <= 14'h0000;
            INSTR_VALID  <= 1'b0;
            daddr_r      <= 9'h000;
            ext_sfr_r    <= 1'b0;
            INT_TAKEN    <= 1'b0;
            RETURN_ADDR  <= `RESET_VECTOR;
        end else begin
            INT_TAKEN <= 1'b0;
            if (phase[0]) begin
                // Fetch this cycle's word while the previous executes.
                PROG_ADDR   <= pc_r & PROG_MASK; // [RQ3] [RQ8] [RQ9]
                pc_r        <= pc_r + 13'h0001; // [RQ5]
                INSTR_WORD  <= fetch_word_r; // [RQ6]
                INSTR_VALID <= ~flush_r; // [RQ4]
                flush_r     <= 1'b0;
                daddr_r     <= daddr_nxt;
                ext_sfr_r   <= ~flush_r && (daddr_nxt[6:0] < `SFR_TOP) &&
                               (daddr_nxt[6:0] != `OFS_INDIRECT_DATA) &&
                               (daddr_nxt[6:0] != `OFS_PC_LOW) &&
                               (daddr_nxt[6:0] != `OFS_STATUS) &&
                               (daddr_nxt[6:0] != `OFS_INDIRECT_PTR) &&
                               (daddr_nxt[6:0] != `OFS_PC_UPPER_LATCH) &&
                               (daddr_nxt[6:0] != `OFS_INT_CONTROL);
            end
            if (phase[3]) begin
                fetch_word_r <= PROG_DATA;
                if (INSTR_VALID && jump_pend_r) begin
                    // Branch: the word just fetched is discarded.
                    pc_r    <= target_r; // [RQ4]
                    flush_r <= 1'b1;
                end else if (INSTR_VALID && wr_pend_r && !ext_sfr_r &&
                             daddr_r[6:0] == `OFS_PC_LOW) begin
                    // Writing the low counter byte is a computed jump.
                    pc_r    <= {upper_latch_r[4:0], wdata_r}; // [RQ4]
                    flush_r <= 1'b1;
                end else if (INT_REQ && int_ctl_r[`IC_GLOBAL_ENABLE]) begin
                    // The word fetched now is resumed after the handler.
                    RETURN_ADDR <= PROG_ADDR;
                    pc_r        <= `INT_VECTOR; // [RQ10]
                    flush_r     <= 1'b1;
                    INT_TAKEN   <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Execute-side capture and register file
    // ----------------------------------------------------------------
    // Results are taken at the end of phase three so the external write
    // strobe can stand through phase four, the destination write phase.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            wr_pend_r    <= 1'b0;
            wdata_r      <= 8'h00;
            flags_pend_r <= 1'b0;
            flags_r      <= 3'h0;
            jump_pend_r  <= 1'b0;
            target_r     <= `RESET_VECTOR;
            OPERAND      <= 8'h00;
            SFR_ADDR     <= 9'h000;
            SFR_RD       <= 1'b0;
            SFR_WR       <= 1'b0;
            SFR_WDATA    <= 8'h00;
        end else begin
            // External read strobe spans phase two only.
            SFR_RD <= phase[0] && ~flush_r && (daddr_nxt[6:0] < `SFR_TOP);
            if (phase[0]) begin
                SFR_ADDR <= daddr_nxt;
            end
            if (phase[1]) begin
                OPERAND <= read_nxt; // [RQ7]
            end
            if (phase[2]) begin
                wr_pend_r    <= EXEC_WR;
                wdata_r      <= EXEC_WDATA;
                flags_pend_r <= EXEC_FLAGS_WR;
                flags_r      <= EXEC_FLAGS;
                jump_pend_r  <= EXEC_PC_LOAD;
                target_r     <= EXEC_PC_TARGET;
                SFR_WR       <= INSTR_VALID && EXEC_WR && ext_sfr_r; // [RQ7]
                SFR_WDATA    <= EXEC_WDATA;
            end
            if (phase[3]) begin
                SFR_WR <= 1'b0;
            end
        end
    end

    // Core register writes land on the phase-four edge. A destination
    // write to status overrides the flag update of the same word.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            status_r      <= `STATUS_RST;
            pointer_r     <= `CORE_REG_RST;
            upper_latch_r <= `CORE_REG_RST;
            int_ctl_r     <= `CORE_REG_RST;
            STATUS_OUT    <= `STATUS_RST;
        end else begin
            STATUS_OUT <= status_r;
            if (phase[3] && INSTR_VALID) begin
                if (flags_pend_r) begin
                    status_r[2:0] <= flags_r;
                end
                if (wr_pend_r) begin
                    case (daddr_r[6:0]) // [RQ17]
                        `OFS_STATUS: begin
                            // Power-down and time-out bits are read only.
                            status_r <= (wdata_r & `ST_WRITE_MASK) |
                                        (status_r & ~`ST_WRITE_MASK); // [RQ7]
                        end
                        `OFS_INDIRECT_PTR: begin
                            pointer_r <= wdata_r;
                        end
                        `OFS_PC_UPPER_LATCH: begin
                            upper_latch_r <= wdata_r;
                        end
                        `OFS_INT_CONTROL: begin
                            int_ctl_r <= wdata_r;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            // Taking an interrupt closes the gate against nesting.
            if (phase[3] && INT_REQ && int_ctl_r[`IC_GLOBAL_ENABLE] &&
                !(INSTR_VALID && jump_pend_r) &&
                !(INSTR_VALID && wr_pend_r && !ext_sfr_r &&
                  daddr_r[6:0] == `OFS_PC_LOW)) begin
                int_ctl_r[`IC_GLOBAL_ENABLE] <= 1'b0;
            end
        end
    end

    // RAM writes; the array itself needs no reset.
    always @(posedge REF_CLK) begin
        if (phase[3] && INSTR_VALID && wr_pend_r && slot[8] &&
            (daddr_r[6:0] >= `SFR_TOP)) begin
            file_mem[slot[7:0]] <= wdata_r; // [RQ7] [RQ13]
        end
    end

    // Phase is presented from a flop for the execution unit.
    always @(posedge REF_CLK) begin
        if (RESET) begin
            PHASE <= 4'h0;
        end else begin
            PHASE <= phase; // [RQ2]
        end
    end

endmodule

// ==== inc/fetch_defs.vh ====
`ifndef FETCH_DEFS_VH
`define FETCH_DEFS_VH

// Core register offsets within the low 32 locations of every bank.
`define OFS_INDIRECT_DATA   7'h00
`define OFS_PC_LOW          7'h02
`define OFS_STATUS          7'h03
`define OFS_INDIRECT_PTR    7'h04
`define OFS_PC_UPPER_LATCH  7'h0a
`define OFS_INT_CONTROL     7'h0b

// Data map boundaries.
`define SFR_TOP             7'h20
`define COMMON_BASE         7'h70
`define BANK2_SMALL_TOP     7'h50

// Register file slot bases for each region.
`define SLOT_BANK0          8'h00
`define SLOT_COMMON         8'h50
`define SLOT_BANK1          8'h60
`define SLOT_BANK2          8'hb0

// Status register field positions.
`define ST_CARRY            0
`define ST_DIGIT_CARRY      1
`define ST_ZERO             2
`define ST_POWER_DOWN       3
`define ST_TIME_OUT         4
`define ST_BANK_LOW         5
`define ST_BANK_HIGH        6
`define ST_INDIRECT_BANK    7

// Interrupt control field positions.
`define IC_GLOBAL_ENABLE    7

// Status bits that software may write.
`define ST_WRITE_MASK       8'he7

// Reset values.
`define STATUS_RST          8'h18
`define CORE_REG_RST        8'h00
`define PHASE_RST           4'h1

// Program vectors.
`define RESET_VECTOR        13'h0000
`define INT_VECTOR          13'h0004

// Phase timing: one instruction cycle is four input clocks.
`define PHASES_PER_CYCLE    4

`endif

// ==== verilog/phase_divider.v ====
`timescale 1ns/1ps
`include "fetch_defs.vh"

// ----------------------------------------------------------------
// Quadrature phase generator
// ----------------------------------------------------------------
// A one-hot ring divides the clock by four. Bit 0 marks phase one,
// bit 3 phase four; exactly one bit is set, so the phases never overlap.
module phase_divider (
    input  wire       clk,
    input  wire       rst,
    output reg  [3:0] phase_r
);

    // The ring rotates once per clock and restarts at phase one.
    always @(posedge clk) begin
        if (rst) begin
            phase_r <= `PHASE_RST;
        end else begin
            phase_r <= {phase_r[2:0], phase_r[3]}; // [RQ1]
        end
    end

endmodule

// ==== dv/program_store_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Program store and peripheral register model
// ----------------------------------------------------------------
// Each word holds its own address, so the low seven bits of a fetched
// word name the data location that a test wants to reach.
module program_store_model (
    input  logic        clk,
    input  logic [12:0] prog_addr,
    output logic [13:0] prog_data,
    input  logic [8:0]  sfr_addr,
    input  logic        sfr_rd,
    output logic [7:0]  sfr_rdata,
    input  logic        sfr_wr,
    input  logic [7:0]  sfr_wdata
);
    logic [7:0] regs [0:511];  // Peripheral register contents.
    logic [7:0] last_r;        // Last value shown on the read bus.
    integer     i;             // Fill index.

    // Seed each register with a value derived from its address.
    initial begin
        last_r = 8'h00;
        for (i = 0; i < 512; i = i + 1) begin
            regs[i] = i[7:0] ^ 8'ha5;
        end
    end

    // Fourteen-bit words; the block already folds the address.
    assign prog_data = {1'h0, prog_addr};

    // Unselected, the bus shows the inverse of its last value, so a read
    // taken at the wrong moment cannot match by luck.
    assign sfr_rdata = sfr_rd ? regs[sfr_addr] : ~last_r;

    // Capture writes and remember what the read bus carried.
    always @(posedge clk) begin
        if (sfr_wr) begin
            regs[sfr_addr] <= sfr_wdata;
        end
        if (sfr_rd) begin
            last_r <= regs[sfr_addr];
        end
    end
endmodule

// ==== dv/fetch_pipeline_checker.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port timing checker
// ----------------------------------------------------------------
module fetch_pipeline_checker #(
    parameter PROG_AW = 11  // Implemented program address bits.
) (
    input logic        REF_CLK,
    input logic        RESET,
    input logic [12:0] PROG_ADDR,
    input logic [3:0]  PHASE,
    input logic [13:0] INSTR_WORD,
    input logic        INSTR_VALID,
    input logic [7:0]  STATUS_OUT,
    input logic        EXEC_WR,
    input logic [7:0]  EXEC_WDATA,
    input logic        EXEC_PC_LOAD,
    input logic [12:0] EXEC_PC_TARGET,
    input logic        INT_TAKEN,
    input logic [8:0]  SFR_ADDR,
    input logic        SFR_RD,
    input logic        SFR_WR,
    input logic [7:0]  SFR_WDATA
);
    // Fetch addresses fold into the implemented space.
    localparam logic [12:0] WRAP_MASK = (13'h1 << PROG_AW) - 13'h1;

    default clocking dclk @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    phase_onehot_a: assert property (!$past(RESET) |-> $onehot(PHASE))
        else $error("phase outputs not one-hot");
    phase_order_a: assert property (
        PHASE == 4'h1 |=> PHASE == 4'h2 ##1 PHASE == 4'h4 ##1 PHASE == 4'h8 ##1 PHASE == 4'h1)
        else $error("phase sequence out of order");
    pc_phase_a: assert property ($changed(PROG_ADDR) |-> PHASE == 4'h1)
        else $error("fetch address moved outside phase one");
    word_hold_a: assert property (
        PHASE != 4'h1 |-> $stable(INSTR_WORD) && $stable(INSTR_VALID) && $stable(SFR_ADDR))
        else $error("instruction word changed mid-cycle");
    read_slot_a: assert property (
        SFR_RD |-> PHASE == 4'h1 && SFR_ADDR[6:0] < 7'h20)
        else $error("register read strobe misplaced");
    write_slot_a: assert property (
        SFR_WR |-> PHASE == 4'h4 && $past(EXEC_WR) && $past(INSTR_VALID)
            && SFR_WDATA == $past(EXEC_WDATA))
        else $error("register write strobe misplaced");
    branch_flush_a: assert property (
        EXEC_PC_LOAD && INSTR_VALID && PHASE == 4'h2 |-> ##3 PHASE == 4'h1 && !INSTR_VALID
            && PROG_ADDR == ($past(EXEC_PC_TARGET, 3) & WRAP_MASK))
        else $error("branch did not flush to target");
    reset_state_a: assert property (
        $fell(RESET) |-> STATUS_OUT == 8'h18 && PROG_ADDR == 13'h0000 && !INSTR_VALID)
        else $error("wrong state after reset");
    int_vector_a: assert property (
        INT_TAKEN |-> ##[1:4] PHASE == 4'h1 && PROG_ADDR == 13'h0004 && !INSTR_VALID)
        else $error("interrupt did not fetch its vector");
    bank_select_a: assert property (
        PHASE == 4'h1 && INSTR_VALID && INSTR_WORD[6:0] != 7'h00
            |-> SFR_ADDR == {STATUS_OUT[6:5], INSTR_WORD[6:0]})
        else $error("data address not formed from bank bits");
endmodule

// ==== dv/fetch_pipeline_memory_map_bench.sv ====
`timescale 1ns/1ps

module fetch_pipeline_memory_map_bench;
    logic        REF_CLK, RESET, INSTR_VALID, EXEC_WR, EXEC_PC_LOAD;
    logic        INT_REQ, INT_TAKEN, SFR_RD, SFR_WR;
    logic [12:0] PROG_ADDR, EXEC_PC_TARGET, RETURN_ADDR;
    logic [13:0] PROG_DATA, INSTR_WORD;
    logic [3:0]  PHASE;
    logic [7:0]  OPERAND, STATUS_OUT, EXEC_WDATA, SFR_RDATA, SFR_WDATA;
    logic [8:0]  SFR_ADDR;
    logic        EXEC_FLAGS_WR;
    logic [2:0]  EXEC_FLAGS;
    integer      failures, n_checks, n_int, i;

    // ----------------------------------------------------------------
    // Block and partner
    // ----------------------------------------------------------------
    // Flag updates and destination writes both reach the status register.
    fetch_pipeline_memory_map #(.PROG_AW(11), .LARGE(0)) fetch_pipeline_memory_map_inst (
        .REF_CLK(REF_CLK), .RESET(RESET), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA),
        .PHASE(PHASE), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
        .OPERAND(OPERAND), .STATUS_OUT(STATUS_OUT), .EXEC_WR(EXEC_WR),
        .EXEC_WDATA(EXEC_WDATA), .EXEC_FLAGS_WR(EXEC_FLAGS_WR), .EXEC_FLAGS(EXEC_FLAGS),
        .EXEC_PC_LOAD(EXEC_PC_LOAD), .EXEC_PC_TARGET(EXEC_PC_TARGET), .INT_REQ(INT_REQ),
        .INT_TAKEN(INT_TAKEN), .RETURN_ADDR(RETURN_ADDR), .SFR_ADDR(SFR_ADDR),
        .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA));
    program_store_model program_store_model_inst (
        .clk(REF_CLK), .prog_addr(PROG_ADDR), .prog_data(PROG_DATA), .sfr_addr(SFR_ADDR),
        .sfr_rd(SFR_RD), .sfr_rdata(SFR_RDATA), .sfr_wr(SFR_WR), .sfr_wdata(SFR_WDATA));

    // Free-running 50 MHz clock.
    initial begin
        REF_CLK = 1'h0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    // Count interrupt acceptances.
    always @(posedge REF_CLK) begin
        if (INT_TAKEN === 1'h1) begin
            n_int <= n_int + 1;
        end
    end

    // Compare and count; unknowns never match.
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Drive the execute requests for the word now shown, then wait for
    // the next cycle; the requests stand across the phase-three edge.
    task go(input logic ld, input logic [12:0] tgt, input logic wr, input logic [7:0] wd);
        integer n;
        EXEC_PC_LOAD = ld;
        EXEC_PC_TARGET = tgt;
        EXEC_WR = wr;
        EXEC_WDATA = wd;
        n = 0;
        do begin
            @(posedge REF_CLK);
            #1;
            n = n + 1;
        end while (PHASE !== 4'h1 && n < 8);
    endtask

    task step;
        go(1'h0, 13'h0000, 1'h0, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Start at zero, then one word per cycle.
    task test_pipeline;
        step;
        chk("valid after reset", 16'h0, {15'h0, INSTR_VALID});
        chk("first fetch", 16'h0, {3'h0, PROG_ADDR});
        for (i = 0; i < 4; i = i + 1) begin
            step;
            chk("word", i[15:0], {2'h0, INSTR_WORD});
            chk("fetch address", i[15:0] + 16'h1, {3'h0, PROG_ADDR});
        end
    endtask

    // A target above the implemented top folds down; one bubble.
    task test_branch_wrap;
        go(1'h1, 13'h1870, 1'h0, 8'h00);
        chk("flushed word", 16'h0, {15'h0, INSTR_VALID});
        chk("wrapped fetch", 16'h0070, {3'h0, PROG_ADDR});
        step;
        chk("target word", 16'h0070, {2'h0, INSTR_WORD});
    endtask

    // Common byte written in bank 0 is read back from bank 3; then a
    // flag update lands in the low status bits without touching the rest.
    task test_banks_common;
        go(1'h0, 13'h0000, 1'h1, 8'h5a);
        go(1'h1, 13'h0083, 1'h0, 8'h00);
        step;
        chk("status address", 16'h0003, {7'h0, SFR_ADDR});
        go(1'h0, 13'h0000, 1'h1, 8'h60);
        chk("bank 3 address", 16'h0184, {7'h0, SFR_ADDR});
        go(1'h1, 13'h0070, 1'h0, 8'h00);
        step;
        chk("status kept bits", 16'h0078, {8'h0, STATUS_OUT});
        chk("common address", 16'h01f0, {7'h0, SFR_ADDR});
        step;
        chk("common data", 16'h005a, {8'h0, OPERAND});
        EXEC_FLAGS_WR = 1'h1;
        EXEC_FLAGS = 3'h5;
        step;
        EXEC_FLAGS_WR = 1'h0;
        chk("flag update", 16'h007d, {8'h0, STATUS_OUT});
    endtask

    // Bank 3 has no RAM at 1A0: writes vanish and reads give zero.
    task test_unmapped;
        go(1'h1, 13'h0020, 1'h0, 8'h00);
        step;
        go(1'h0, 13'h0000, 1'h1, 8'h77);
        go(1'h1, 13'h0020, 1'h0, 8'h00);
        step;
        step;
        chk("unmapped read", 16'h0000, {8'h0, OPERAND});
    endtask

    // Enable interrupts, read an external register while one arrives.
    task test_sfr_interrupt;
        go(1'h1, 13'h000b, 1'h0, 8'h00);
        step;
        go(1'h0, 13'h0000, 1'h1, 8'h80);
        INT_REQ = 1'h1;
        go(1'h0, 13'h0000, 1'h1, 8'h3c);
        chk("external read", 16'h0029, {8'h0, OPERAND});
        chk("return address", 16'h000d, {3'h0, RETURN_ADDR});
        chk("interrupt bubble", 16'h0, {15'h0, INSTR_VALID});
        INT_REQ = 1'h0;
        step;
        chk("vector word", 16'h0004, {2'h0, INSTR_WORD});
        chk("interrupt count", 16'h1, n_int[15:0]);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence: reset for six cycles, then the scenarios.
    initial begin
        failures = 0;
        n_checks = 0;
        n_int = 0;
        RESET = 1'h1;
        INT_REQ = 1'h0;
        EXEC_WR = 1'h0;
        EXEC_WDATA = 8'h00;
        EXEC_PC_LOAD = 1'h0;
        EXEC_PC_TARGET = 13'h0000;
        EXEC_FLAGS_WR = 1'h0;
        EXEC_FLAGS = 3'h0;
        repeat (6) @(posedge REF_CLK);
        #1;
        RESET = 1'h0;
        test_pipeline;
        test_branch_wrap;
        test_banks_common;
        test_unmapped;
        test_sfr_interrupt;
        summarize;
    end

    // The run needs about 110 cycles; 2000 means a hang.
    initial begin
        #40000;
        failures = failures + 1;
        summarize;
    end
endmodule

bind fetch_pipeline_memory_map fetch_pipeline_checker #(.PROG_AW(PROG_AW))
    fetch_pipeline_checker_inst (
    .REF_CLK(REF_CLK), .RESET(RESET), .PROG_ADDR(PROG_ADDR), .PHASE(PHASE),
    .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID), .STATUS_OUT(STATUS_OUT),
    .EXEC_WR(EXEC_WR), .EXEC_WDATA(EXEC_WDATA), .EXEC_PC_LOAD(EXEC_PC_LOAD),
    .EXEC_PC_TARGET(EXEC_PC_TARGET), .INT_TAKEN(INT_TAKEN), .SFR_ADDR(SFR_ADDR),
    .SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA));
